// >>> rtl/uart_cfg_pkg.sv
// Constants shared by the serial port mode configuration block.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package uart_cfg_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_MODE = 8'h00; // Mode control
    localparam logic [7:0] OFF_RATE = 8'h04; // Baud generator divisor
    localparam logic [7:0] OFF_STAT = 8'h08; // Sticky event status
    localparam logic [7:0] OFF_INTEN = 8'h0c; // Interrupt enable
    localparam logic [7:0] OFF_INTCLR = 8'h10; // Write-one-to-clear
    localparam logic [7:0] OFF_AUX = 8'h14; // Transmit options

    // Mode register field positions
    localparam int unsigned BIT_IR_EN = 12; // Infrared codec enable
    localparam int unsigned BIT_PIN_LO = 8; // Pin enable select, low bit
    localparam int unsigned BIT_WAKE = 7; // Wake on start bit
    localparam int unsigned BIT_AUTO = 5; // Auto rate measure enable
    localparam int unsigned BIT_HS = 3; // High speed oversample select
    localparam int unsigned BIT_FMT_LO = 1; // Frame format select, low bit
    localparam int unsigned BIT_STOP = 0; // Stop count select

    // Auxiliary register field positions
    localparam int unsigned BIT_TX_INV = 0; // Transmit idle invert

    // Status, enable and clear layout
    localparam int unsigned EVT_WAKE = 0; // Start bit seen in sleep
    localparam int unsigned EVT_RATE = 1; // Rate measurement done
    localparam int unsigned EVT_N = 2; // Number of event bits

    // Which pin enable select bits exist on this variant
    localparam logic [1:0] PIN_SEL_PRESENT = 2'h3;
    // Writable mode bits apart from the pin enable select field
    localparam logic [15:0] MODE_BASE_MASK = 16'h10af;
    localparam logic [15:0] MODE_WR_MASK =
        MODE_BASE_MASK | {6'h00, PIN_SEL_PRESENT, 8'h00};

    // Reset values
    localparam logic [15:0] MODE_RESET = 16'h0000;
    localparam logic [15:0] RATE_RESET = 16'h0000;

    // Frame format encodings
    localparam logic [1:0] FMT_8N = 2'h0; // 8 data, no parity
    localparam logic [1:0] FMT_8E = 2'h1; // 8 data, even parity
    localparam logic [1:0] FMT_8O = 2'h2; // 8 data, odd parity
    localparam logic [1:0] FMT_9N = 2'h3; // 9 data, no parity

    // Oversampling clocks per bit period
    localparam logic [3:0] OS_LAST_STD = 4'hf; // 16 clocks, last index
    localparam logic [3:0] OS_LAST_HS = 4'h3; // 4 clocks, last index

    // Sync character falling edges after the start edge spanning 8 bits
    localparam logic [2:0] SYNC_FALLS = 3'h4;
    // Shift that divides 8 bit times into clocks per oversample tick
    localparam int unsigned SHIFT_STD = 7; // 8 * 16
    localparam int unsigned SHIFT_HS = 5; // 8 * 4
    localparam int unsigned MEAS_W = 24; // Measure counter width

endpackage

// >>> rtl/rx_pin_sync.sv
// Two-stage synchroniser for the receive pin with edge pulses.
// Assumes the pin idles high and is asynchronous to clk_i.
`timescale 1ns/1ps
module rx_pin_sync
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic level_o,
    output logic fall_o,
    output logic rise_o
);
    logic meta; // First stage, read only by the second
    logic stable; // Second stage
    logic hist; // Previous stable value for edge detection
    logic next_meta;
    logic next_stable;
    logic next_hist;

    // Shift the pin through the stages
    always_comb
    begin
        next_meta = pin_i;
        next_stable = meta;
        next_hist = stable;
    end

    // Idle-high reset avoids a false start edge after reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta <= 1'b1;
            stable <= 1'b1;
            hist <= 1'b1;
        end
        else
        begin
            meta <= next_meta;
            stable <= next_stable;
            hist <= next_hist;
        end
    end

    assign level_o = stable;
    assign fall_o = hist & ~stable;
    assign rise_o = ~hist & stable;
endmodule // rx_pin_sync

// >>> rtl/baud_tick_gen.sv
// Baud generator: divisor-based oversample tick and bit-period tick.
// Assumes divisor and speed select come from registers on clk_i.
`timescale 1ns/1ps
module baud_tick_gen
    import uart_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] divisor_i,
    input wire logic high_speed_i,
    output logic os_tick_o,
    output logic bit_tick_o
);
    logic [15:0] cnt; // Down counter to the next oversample tick
    logic [3:0] phase; // Oversample index inside the bit period
    logic os_tick;
    logic bit_tick;
    logic [15:0] next_cnt;
    logic [3:0] next_phase;
    logic next_os_tick;
    logic next_bit_tick;
    logic [3:0] last; // Last phase index for the chosen rate

    // Divide down, then group 4 or 16 ticks into a bit period
    always_comb
    begin
        last = high_speed_i ? OS_LAST_HS : OS_LAST_STD; // see R3
        next_cnt = cnt - 16'h0001;
        next_phase = phase;
        next_os_tick = 1'b0;
        next_bit_tick = 1'b0;
        if (cnt == 16'h0000)
        begin
            next_cnt = divisor_i;
            next_os_tick = 1'b1;
            if (phase >= last)
            begin
                // Also recovers if the rate shrinks mid-period
                next_phase = 4'h0;
                next_bit_tick = 1'b1; // see R3
            end
            else
            begin
                next_phase = phase + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt <= 16'h0000;
            phase <= 4'h0;
            os_tick <= 1'b0;
            bit_tick <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            phase <= next_phase;
            os_tick <= next_os_tick;
            bit_tick <= next_bit_tick;
        end
    end

    assign os_tick_o = os_tick;
    assign bit_tick_o = bit_tick;

    // Helper: oversample ticks seen since the last bit tick
    logic [4:0] seen;
    logic seen_ok;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            seen <= 5'h00;
            seen_ok <= 1'b0;
        end
        else if (bit_tick || (high_speed_i != $past(high_speed_i)))
        begin
            seen <= 5'h00;
            seen_ok <= bit_tick;
        end
        else if (os_tick)
        begin
            seen <= seen + 5'h01;
        end
    end

    a_bit_period_len: assert property ( // see R3
        @(posedge clk_i) disable iff (rst_i)
        bit_tick && seen_ok && $stable(high_speed_i) |->
            (seen == (high_speed_i ? 5'h03 : 5'h0f)))
        else $error("bit period has wrong oversample count");
endmodule // baud_tick_gen

// >>> rtl/uart_mode_config.sv
// Serial port mode configuration: register file, auto rate
// measurement, wake on start bit and frame format decode.
// Assumes a classic Wishbone master and an idle-high receive pin.
//
// Function
// R1: Auto rate measures 55h sync, then self-clears.
// R2: Infrared and idle invert need 16x mode.
// R3: High speed gives 4, else 16 clocks.
// R4: Format 11 means 9 data, no parity.
// R5: Formats 10 odd, 01 even, 00 none.
// R6: Stop select 1 gives two stop bits.
// R7: Pin select bits absent without pins.
// R8: Infrared enable routes pins through codec.
// R9: Wake interrupts on fall, clears on rise.
`timescale 1ns/1ps
module uart_mode_config
    import uart_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic serial_receive_pin_i,
    input wire logic sleep_i,
    output logic irq_o,
    output logic os_tick_o,
    output logic bit_tick_o,
    output logic rx_level_o,
    output logic data_bits_nine_o,
    output logic parity_enable_o,
    output logic parity_odd_o,
    output logic two_stop_o,
    output logic infrared_codec_active_o,
    output logic transmit_idle_invert_o,
    output logic [1:0] pin_enable_select_o
);
    // All checks below run on the one clock and pause in reset
    default clocking check_clk @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // Auto rate measurement states
    typedef enum logic [2:0]
    {
        AB_IDLE = 3'b001,
        AB_WAIT = 3'b010,
        AB_MEAS = 3'b100
    } ab_state_t;

    // Register file
    logic [15:0] serial_port_mode_control; // Mode control
    logic [15:0] rate; // Baud generator divisor
    logic [EVT_N-1:0] stat; // Sticky events
    logic [EVT_N-1:0] inten; // Interrupt enable
    logic [15:0] aux; // Transmit options
    logic [15:0] next_mode;
    logic [15:0] next_rate;
    logic [EVT_N-1:0] next_stat;
    logic [EVT_N-1:0] next_inten;
    logic [15:0] next_aux;

    // Bus state
    logic ack; // Registered acknowledge
    logic [31:0] rdata; // Registered read data
    logic next_ack;
    logic [31:0] next_rdata;

    // Auto rate measurement state
    ab_state_t ab_state;
    ab_state_t next_ab_state;
    logic [MEAS_W-1:0] ab_cnt; // Clocks since the start edge
    logic [MEAS_W-1:0] next_ab_cnt;
    logic [2:0] ab_falls; // Falling edges after the start edge
    logic [2:0] next_ab_falls;
    logic ab_done; // Measurement finished this cycle
    logic [15:0] ab_div; // Divisor derived from the measurement

    // Wake state
    logic wake_armed; // Start edge seen, waiting for the rise
    logic next_wake_armed;
    logic wake_evt; // Start edge during sleep
    logic wake_clear; // Rising edge that ends the wake

    // Receive pin edges
    logic rx_fall;
    logic rx_rise;

    // Bus decode
    logic req; // New request not yet answered
    logic wr; // Write strobe, one cycle
    logic hs; // High speed select
    logic [15:0] wdata16; // Low half of write data

    assign req = wb_cyc_i & wb_stb_i & ~ack;
    assign wr = req & wb_we_i;
    assign wdata16 = wb_dat_i[15:0];
    assign hs = serial_port_mode_control[BIT_HS];

    // Byte-lane merge for the 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] nw,
                                            input logic [1:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0])
        begin
            r[7:0] = nw[7:0];
        end
        if (sel[1])
        begin
            r[15:8] = nw[15:8];
        end
        return r;
    endfunction

    rx_pin_sync u_rx_sync
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(serial_receive_pin_i),
        .level_o(rx_level_o),
        .fall_o(rx_fall),
        .rise_o(rx_rise)
    );

    baud_tick_gen u_baud_generator
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .divisor_i(rate),
        .high_speed_i(hs),
        .os_tick_o(os_tick_o),
        .bit_tick_o(bit_tick_o)
    );

    // Auto rate: time four more falls of 55h, i.e. eight bit times
    always_comb
    begin
        next_ab_state = ab_state;
        next_ab_cnt = ab_cnt;
        next_ab_falls = ab_falls;
        ab_done = 1'b0;
        // Divide 8 bit times by 16 or 4 ticks; saturate, floor at 0
        if (ab_cnt[MEAS_W-1] || (hs && ab_cnt[22:21] != 2'h0))
        begin
            ab_div = 16'hffff; // Too long for the divisor
        end
        else if (hs)
        begin
            ab_div = ab_cnt[20:5] - 16'h0001;
        end
        else
        begin
            ab_div = ab_cnt[22:7] - 16'h0001;
        end
        if (ab_div == 16'hffff && !ab_cnt[MEAS_W-1]
            && (hs ? ab_cnt[20:5] : ab_cnt[22:7]) == 16'h0000)
        begin
            ab_div = 16'h0000; // Too short to divide
        end
        case (ab_state)
            AB_IDLE:
            begin
                if (serial_port_mode_control[BIT_AUTO])
                begin
                    next_ab_state = AB_WAIT; // see R1
                end
            end
            AB_WAIT:
            begin
                if (!serial_port_mode_control[BIT_AUTO])
                begin
                    next_ab_state = AB_IDLE; // Software withdrew it
                end
                else if (rx_fall)
                begin
                    // Start bit of the sync character
                    next_ab_state = AB_MEAS;
                    next_ab_cnt = '0;
                    next_ab_falls = 3'h0;
                end
            end
            AB_MEAS:
            begin
                if (!ab_cnt[MEAS_W-1])
                begin
                    next_ab_cnt = ab_cnt + 1'b1;
                end
                if (!serial_port_mode_control[BIT_AUTO])
                begin
                    next_ab_state = AB_IDLE;
                end
                else if (rx_fall)
                begin
                    next_ab_falls = ab_falls + 3'h1;
                    if (next_ab_falls == SYNC_FALLS)
                    begin
                        ab_done = 1'b1; // see R1
                        next_ab_state = AB_IDLE;
                    end
                end
            end
            default:
            begin
                next_ab_state = AB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ab_state <= AB_IDLE;
            ab_cnt <= '0;
            ab_falls <= 3'h0;
        end
        else
        begin
            ab_state <= next_ab_state;
            ab_cnt <= next_ab_cnt;
            ab_falls <= next_ab_falls;
        end
    end

    // Wake: arm on the start edge in sleep, release on the next rise
    always_comb
    begin
        wake_evt = serial_port_mode_control[BIT_WAKE] & sleep_i
                   & rx_fall; // see R9
        wake_clear = wake_armed & rx_rise; // see R9
        next_wake_armed = wake_armed;
        if (!serial_port_mode_control[BIT_WAKE] || wake_clear)
        begin
            next_wake_armed = 1'b0;
        end
        else if (wake_evt)
        begin
            next_wake_armed = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wake_armed <= 1'b0;
        end
        else
        begin
            wake_armed <= next_wake_armed;
        end
    end

    // Register writes; hardware clears follow a same-cycle write
    always_comb
    begin
        next_mode = serial_port_mode_control;
        next_rate = rate;
        next_stat = stat;
        next_inten = inten;
        next_aux = aux;
        if (wr && wb_adr_i == OFF_MODE)
        begin
            // Absent pin select bits stay zero
            next_mode = merge16(serial_port_mode_control, wdata16,
                                wb_sel_i[1:0]) & MODE_WR_MASK; // see R7
        end
        if (wr && wb_adr_i == OFF_RATE)
        begin
            next_rate = merge16(rate, wdata16, wb_sel_i[1:0]);
        end
        if (wr && wb_adr_i == OFF_INTEN && wb_sel_i[0])
        begin
            next_inten = wb_dat_i[EVT_N-1:0];
        end
        if (wr && wb_adr_i == OFF_INTCLR && wb_sel_i[0])
        begin
            next_stat = stat & ~wb_dat_i[EVT_N-1:0];
        end
        if (wr && wb_adr_i == OFF_AUX)
        begin
            next_aux = merge16(aux, wdata16, wb_sel_i[1:0]) & 16'h0001;
        end
        if (ab_done)
        begin
            next_mode[BIT_AUTO] = 1'b0; // see R1
            next_rate = ab_div; // see R1
        end
        if (wake_clear)
        begin
            next_mode[BIT_WAKE] = 1'b0; // see R9
        end
        // Events win over a clear in the same cycle
        next_stat[EVT_WAKE] = next_stat[EVT_WAKE] | wake_evt; // see R9
        next_stat[EVT_RATE] = next_stat[EVT_RATE] | ab_done;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            serial_port_mode_control <= MODE_RESET;
            rate <= RATE_RESET;
            stat <= '0;
            inten <= '0;
            aux <= 16'h0000;
        end
        else
        begin
            serial_port_mode_control <= next_mode;
            rate <= next_rate;
            stat <= next_stat;
            inten <= next_inten;
            aux <= next_aux;
        end
    end

    // Bus answer: one wait state, unmapped reads return zero
    always_comb
    begin
        next_ack = req;
        next_rdata = rdata;
        if (req && !wb_we_i)
        begin
            case (wb_adr_i)
                OFF_MODE: next_rdata = {16'h0000, serial_port_mode_control};
                OFF_RATE: next_rdata = {16'h0000, rate};
                OFF_STAT: next_rdata = {30'h0, stat};
                OFF_INTEN: next_rdata = {30'h0, inten};
                OFF_AUX: next_rdata = {16'h0000, aux};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end
        else
        begin
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;
    assign irq_o = |(stat & inten);

    // Configuration decode towards the transmitter and receiver
    assign data_bits_nine_o =
        serial_port_mode_control[2:1] == FMT_9N; // see R4
    assign parity_enable_o = serial_port_mode_control[2:1] == FMT_8O
        || serial_port_mode_control[2:1] == FMT_8E; // see R5
    assign parity_odd_o = serial_port_mode_control[2:1] == FMT_8O; // see R5
    assign two_stop_o = serial_port_mode_control[BIT_STOP]; // see R6
    // Options that rely on 16x timing are masked in 4x mode
    assign infrared_codec_active_o =
        serial_port_mode_control[BIT_IR_EN] & ~hs; // see R2, R8
    assign transmit_idle_invert_o = aux[BIT_TX_INV] & ~hs; // see R2
    assign pin_enable_select_o =
        serial_port_mode_control[9:8] & PIN_SEL_PRESENT; // see R7

    a_rate_done_clear: assert property ( // see R1
        ab_state == AB_MEAS && rx_fall && ab_falls == 3'h3 &&
            serial_port_mode_control[BIT_AUTO] |=>
            !serial_port_mode_control[BIT_AUTO] && stat[EVT_RATE])
        else $error("auto rate did not finish on fourth fall");
    a_ir_needs_std: assert property ( // see R2
        infrared_codec_active_o |-> !serial_port_mode_control[BIT_HS])
        else $error("infrared active in 4x mode");
    a_inv_needs_std: assert property ( // see R2
        transmit_idle_invert_o |-> !hs && aux[BIT_TX_INV])
        else $error("idle invert active in 4x mode");
    a_nine_bit_fmt: assert property ( // see R4
        serial_port_mode_control[2:1] == 2'h3 |->
            data_bits_nine_o && !parity_enable_o)
        else $error("format 11 not nine bits no parity");
    a_parity_fmt: assert property ( // see R5
        serial_port_mode_control[2:1] != 2'h3 |-> !data_bits_nine_o &&
            parity_enable_o == (serial_port_mode_control[2:1] != 2'h0) &&
            parity_odd_o == (serial_port_mode_control[2:1] == 2'h2))
        else $error("parity decode wrong");
    a_stop_count: assert property ( // see R6
        $rose(serial_port_mode_control[0]) |-> two_stop_o)
        else $error("stop count does not follow select");
    a_absent_pins: assert property ( // see R7
        (serial_port_mode_control[9:8] & ~PIN_SEL_PRESENT) == 2'h0)
        else $error("absent pin select bit set");
    a_ir_route: assert property ( // see R8
        serial_port_mode_control[BIT_IR_EN] && !hs |-> infrared_codec_active_o)
        else $error("infrared enable not routed");
    a_wake_irq: assert property ( // see R9
        wake_evt && inten[EVT_WAKE] |=> stat[EVT_WAKE] && irq_o)
        else $error("wake edge raised no interrupt");
    a_wake_clear: assert property ( // see R9
        wake_armed && rx_rise |=> !serial_port_mode_control[BIT_WAKE])
        else $error("wake not cleared on rising edge");
    a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    c_rate_done: cover property (@(posedge clk_i) disable iff (rst_i)
        ab_done);
    c_wake_seen: cover property (@(posedge clk_i) disable iff (rst_i)
        wake_evt ##[1:1000] wake_clear);
    c_bus_write: cover property (@(posedge clk_i) disable iff (rst_i)
        wr ##1 wb_ack_o);
endmodule // uart_mode_config

// >>> testbench/remote_serial_model.sv
// Remote serial transmitter that drives the receive pin.
// Assumes frame format and stop count mirror the block's decodes.
`timescale 1ns/1ps
module remote_serial_model
(
    input wire logic clk_i,
    input wire logic send_i,
    input wire logic [8:0] data_i,
    input wire logic [15:0] bit_len_i,
    input wire logic nine_i,
    input wire logic parity_enable_i,
    input wire logic parity_odd_i,
    input wire logic two_stop_i,
    output logic line_o,
    output logic busy_o
);
    logic q[$]; // Bits of the frame, first out at the front
    int i;
    // One frame per send request; line idles high between frames
    initial
    begin
        line_o = 1'b1;
        busy_o = 1'b0;
        forever
        begin
            @(posedge clk_i);
            if (send_i)
            begin
                busy_o <= 1'b1;
                q = {1'b0};
                for (i = 0; i < (nine_i ? 9 : 8); i++)
                    q.push_back(data_i[i]);
                if (parity_enable_i)
                    q.push_back(^data_i[7:0] ^ parity_odd_i);
                q.push_back(1'b1);
                if (two_stop_i)
                    q.push_back(1'b1);
                foreach (q[k])
                begin
                    line_o <= q[k];
                    repeat (bit_len_i) @(posedge clk_i);
                end
                busy_o <= 1'b0;
            end
        end
    end
endmodule // remote_serial_model

// >>> testbench/uart_mode_config_test.sv
// Self-checking bench for the mode configuration block.
// Assumes the remote serial model and the design files are compiled.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    err_count++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module uart_mode_config_test;
    import uart_cfg_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sleep = 0;
    logic send = 0;
    logic [7:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] wdat = 0, rdat, dat_o;
    logic [8:0] sdata = 0;
    logic ack, irq, ost, bt, rxl, nine, pen, podd, two, ira, inv, line, busy;
    logic [1:0] pins;
    int err_count = 0, total_checks = 0, cycles = 0, n, f, s;
    uart_mode_config dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .serial_receive_pin_i(line), .sleep_i(sleep), .irq_o(irq),
        .os_tick_o(ost), .bit_tick_o(bt), .rx_level_o(rxl),
        .data_bits_nine_o(nine), .parity_enable_o(pen),
        .parity_odd_o(podd), .two_stop_o(two),
        .infrared_codec_active_o(ira), .transmit_idle_invert_o(inv),
        .pin_enable_select_o(pins));
    remote_serial_model peer_u (.clk_i(clk_i), .send_i(send),
        .data_i(sdata), .bit_len_i(16'h0028), .nine_i(nine),
        .parity_enable_i(pen), .parity_odd_i(podd), .two_stop_i(two),
        .line_o(line), .busy_o(busy));
    initial
    begin
        forever #4 clk_i = ~clk_i;
    end
    task finish_test;
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Cuts a hang short; the longest frame test needs well under this
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            err_count++;
            finish_test;
        end
    end
    // Classic single Wishbone cycle, held until ack is sampled high
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 0; stb <= 0; we <= 0;
        @(posedge clk_i);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK("read", e, rdat)
    endtask
    // One frame from the peer, then time for the pin synchroniser
    task frame(input logic [8:0] d);
        sdata <= d; send <= 1;
        @(posedge clk_i);
        send <= 0;
        @(posedge clk_i);
        while (busy) @(posedge clk_i);
        repeat (8) @(posedge clk_i);
    endtask
    task gap(input int e);
        while (bt !== 1'b1) @(posedge clk_i);
        n = 0;
        do begin @(posedge clk_i); n++; end while (bt !== 1'b1);
        `CHK("bit_gap", e, n)
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        rc(OFF_MODE, 32'h0);
        rc(OFF_STAT, 32'h0);
        `CHK("rx_idle", 1'b1, rxl)
        rc(8'h20, 32'h0);
        wb(1'b1, OFF_MODE, 32'hffff);
        rc(OFF_MODE, 32'h13af);
        `CHK("pins", 2'h3, pins)
        for (f = 0; f < 4; f++)
            for (s = 0; s < 2; s++)
            begin
                wb(1'b1, OFF_MODE, (f << 1) | s);
                `CHK("nine", f == 3, nine)
                `CHK("par", f == 1 || f == 2, pen)
                `CHK("odd", f == 2, podd)
                `CHK("stop", s == 1, two)
            end
        wb(1'b1, OFF_AUX, 32'h1);
        wb(1'b1, OFF_MODE, 32'h1008);
        `CHK("ir_hs", 1'b0, ira)
        `CHK("inv_hs", 1'b0, inv)
        wb(1'b1, OFF_MODE, 32'h1000);
        `CHK("ir", 1'b1, ira)
        `CHK("inv", 1'b1, inv)
        // 40 clocks a bit: 320 clocks over 8 bits gives divisor 1
        wb(1'b1, OFF_INTEN, 32'h3);
        wb(1'b1, OFF_MODE, 32'h20);
        frame(9'h055);
        rc(OFF_MODE, 32'h0);
        rc(OFF_RATE, 32'h1);
        rc(OFF_STAT, 32'h2);
        `CHK("irq_rate", 1'b1, irq)
        wb(1'b1, OFF_INTEN, 32'h0);
        `CHK("irq_mask", 1'b0, irq)
        wb(1'b1, OFF_INTCLR, 32'h3);
        rc(OFF_STAT, 32'h0);
        wb(1'b1, OFF_INTEN, 32'h1);
        sleep <= 1;
        wb(1'b1, OFF_MODE, 32'h87);
        frame(9'h1a5);
        rc(OFF_STAT, 32'h1);
        `CHK("irq_wake", 1'b1, irq)
        rc(OFF_MODE, 32'h7);
        wb(1'b1, OFF_INTCLR, 32'h1);
        `CHK("irq_clr", 1'b0, irq)
        wb(1'b1, OFF_RATE, 32'h0);
        wb(1'b1, OFF_MODE, 32'h0);
        gap(16);
        `CHK("os_tick", 1'b1, ost)
        wb(1'b1, OFF_MODE, 32'h8);
        gap(4);
        finish_test;
    end
endmodule // uart_mode_config_test
